// ### clpp_pkg.sv
// Purpose: constants, register map and types of the closed-loop pulse positioner
// Assumes: 25 MHz mclk, 32-bit AXI4-Lite register access
// Notes:   every channel owns a 64-byte window of registers
package clpp_pkg;
	// timing
	localparam int unsigned CLK_NS    = 40;
	localparam int unsigned MS_NS     = 1000000;
	localparam int unsigned MS_CYCLES = MS_NS / CLK_NS;
	localparam logic [31:0] CLK_HZ    = 32'h017d_7840;
	localparam int unsigned NCH       = 2;

	// register offsets inside a channel window
	localparam logic [5:0] OFS_CTRL     = 6'h00;
	localparam logic [5:0] OFS_TGT_CNT  = 6'h04;
	localparam logic [5:0] OFS_TGT_FREQ = 6'h08;
	localparam logic [5:0] OFS_SE_FREQ  = 6'h0c;
	localparam logic [5:0] OFS_RAMP     = 6'h10;
	localparam logic [5:0] OFS_RAMP_DN  = 6'h14;
	localparam logic [5:0] OFS_RATIO    = 6'h18;
	localparam logic [5:0] OFS_IDLE     = 6'h1c;
	localparam logic [5:0] OFS_PV_LO    = 6'h20;
	localparam logic [5:0] OFS_PV_HI    = 6'h24;
	localparam logic [5:0] OFS_STAT     = 6'h28;
	localparam logic [5:0] OFS_MASK     = 6'h2c;

	// control bits
	localparam int CTRL_RUN   = 0;
	localparam int CTRL_SRC   = 1;
	localparam int CTRL_RDSEL = 2;
	localparam int CTRL_REV   = 3;
	localparam int CTRL_PAUSE = 4;

	// reset values
	localparam logic [31:0] SE_FREQ_RST4 = 32'h0000_00c8;
	localparam logic [31:0] SE_FREQ_RST2 = 32'h0000_0064;
	localparam logic [31:0] RAMP_RST     = 32'h0000_0064;
	localparam logic [31:0] RATIO_RST    = 32'h0000_0064;
	localparam logic [31:0] IDLE_RST     = 32'h0000_ffff;
	localparam logic [31:0] MASK_RST     = 32'h0000_0000;

	// limits of the two variants
	localparam logic [31:0] F4_MIN    = 32'h0000_000a;
	localparam logic [31:0] F4_MAX    = 32'h0003_0d40;
	localparam logic [31:0] F2_MIN    = 32'h0000_0006;
	localparam logic [31:0] F2_MAX    = 32'h0001_86a0;
	localparam logic [31:0] R4_MIN    = 32'h0000_000a;
	localparam logic [31:0] R4_MAX    = 32'h0000_2710;
	localparam logic [31:0] R2_MIN    = 32'h0000_0014;
	localparam logic [31:0] RATIO_MIN = 32'h0000_0001;
	localparam logic [31:0] RATIO_MAX = 32'h0000_2710;
	localparam logic [47:0] RATIO_DEN = 48'h0000_0000_0064;
	localparam logic [47:0] DEC_DIV   = 48'h0000_0000_07d0;

	typedef enum logic [2:0] {
		PH_IDLE   = 3'b000,
		PH_ACCEL  = 3'b001,
		PH_CRUISE = 3'b010,
		PH_DECEL  = 3'b011,
		PH_DWELL  = 3'b100,
		PH_DONE   = 3'b101
	} clpp_phase_e;

	typedef struct packed {
		logic [4:0]  ctrl;
		logic [31:0] tgt_cnt;
		logic [31:0] tgt_freq;
		logic [31:0] se_freq;
		logic [31:0] ramp;
		logic [31:0] ramp_dn;
		logic [31:0] ratio;
		logic [31:0] idle_lim;
		logic [31:0] mask;
	} clpp_cfg_s;
endpackage

// ### clpp_positioner.sv
// Purpose: closed-loop positioning pulse generator, two channels, AXI4-Lite registers
// Assumes: feedback pulse and stop inputs are synchronous one-cycle strobes
// Notes:   TWO_CH_LIMITS picks the limit set of the two-channel variant
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module clpp_positioner #(
	parameter bit          TWO_CH_LIMITS = 1'b0,
	parameter int unsigned MS_TICKS      = clpp_pkg::MS_CYCLES
) (
	// clock and reset
	input  wire  logic                      mclk,
	input  wire  logic                      reset,
	// axi4-lite write
	input  wire  logic [7:0]                awaddr,
	input  wire  logic                      awvalid,
	output logic                            awready,
	input  wire  logic [31:0]               wdata,
	input  wire  logic [3:0]                wstrb,
	input  wire  logic                      wvalid,
	output logic                            wready,
	output logic [1:0]                      bresp,
	output logic                            bvalid,
	input  wire  logic                      bready,
	// axi4-lite read
	input  wire  logic [7:0]                araddr,
	input  wire  logic                      arvalid,
	output logic                            arready,
	output logic [31:0]                     rdata,
	output logic [1:0]                      rresp,
	output logic                            rvalid,
	input  wire  logic                      rready,
	// feedback
	input  wire  logic [clpp_pkg::NCH-1:0]  fb_pulse,
	input  wire  logic [clpp_pkg::NCH-1:0]  stop_irq,
	// motor drive
	output logic [clpp_pkg::NCH-1:0]        pulse_out_pin,
	output logic [clpp_pkg::NCH-1:0]        dir_out_pin
);
	import clpp_pkg::*;
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction
	logic        aw_full_q;
	logic [7:0]  aw_addr_q;
	logic        w_full_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic [31:0] ch_rd [NCH];
	wire         wr_fire = aw_full_q & w_full_q & ~bvalid_q;
	wire  [5:0]  wr_ofs  = aw_addr_q[5:0];
	wire         wr_ch   = aw_addr_q[6];
	wire         wr_hit  = ~aw_addr_q[7] & (wr_ofs <= OFS_MASK) & (wr_ofs[1:0] == 2'b00);
	wire         rd_hit  = ~araddr[7] & (araddr[5:0] <= OFS_MASK) & (araddr[1:0] == 2'b00);
	wire         rd_fire = arvalid & ~rvalid_q;
	assign awready = ~aw_full_q;
	assign wready  = ~w_full_q;
	assign arready = ~rvalid_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;
	assign rvalid  = rvalid_q;
	assign rdata   = rdata_q;
	assign rresp   = rresp_q;
	// address and data are held separately so the master may offer them in either order
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_full_q  <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
		end else begin
			if (awvalid && !aw_full_q) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= awaddr;
			end else if (wr_fire) begin
				aw_full_q <= 1'b0;
			end
			if (wvalid && !w_full_q) begin
				w_full_q <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end else if (wr_fire) begin
				w_full_q <= 1'b0;
			end
		end
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			bvalid_q <= 1'b0;
			bresp_q  <= 2'b00;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_hit ? 2'b00 : 2'b11;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= 2'b00;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_hit ? ch_rd[araddr[6]] : 32'h0000_0000;
			rresp_q  <= rd_hit ? 2'b00 : 2'b11;
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end
	localparam logic [31:0] FMIN  = TWO_CH_LIMITS ? F2_MIN : F4_MIN;
	localparam logic [31:0] FMAX  = TWO_CH_LIMITS ? F2_MAX : F4_MAX;
	localparam logic [31:0] SERST = TWO_CH_LIMITS ? SE_FREQ_RST2 : SE_FREQ_RST4;
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		clpp_cfg_s   cfg_q;
		clpp_phase_e st_q;
		logic        run_q;
		logic        pulse_q;
		logic        dir_q;
		logic        done_q;
		logic [31:0] freq_q;
		logic [31:0] up_step_q;
		logic [31:0] dn_step_q;
		logic [31:0] ms_cnt_q;
		logic [31:0] acc_q;
		logic [31:0] pv_q;
		logic [31:0] fb_cnt_q;
		logic [31:0] idle_cnt_q;
		logic [47:0] out_cnt_q;
		logic [47:0] cmd_q;
		wire         run    = cfg_q.ctrl[CTRL_RUN];
		wire         pause  = cfg_q.ctrl[CTRL_PAUSE];
		wire         src_it = cfg_q.ctrl[CTRL_SRC];
		wire         wr_me  = wr_fire & wr_hit & (wr_ch == 1'(i));
		wire         neg    = cfg_q.tgt_cnt[31];
		wire  [31:0] mag    = neg ? (~cfg_q.tgt_cnt + 32'h1) : cfg_q.tgt_cnt;
		wire  [31:0] tgt_f  = (cfg_q.tgt_freq < FMIN) ? FMIN :
			((cfg_q.tgt_freq > FMAX) ? FMAX : cfg_q.tgt_freq);
		wire  [31:0] se_min = (cfg_q.se_freq < FMIN) ? FMIN : cfg_q.se_freq;
		wire  [31:0] start_f = (se_min > tgt_f) ? tgt_f : se_min;
		wire  [31:0] ramp_up = TWO_CH_LIMITS ? ((cfg_q.ramp < R2_MIN) ? R2_MIN : cfg_q.ramp) :
			((cfg_q.ramp < R4_MIN || cfg_q.ramp > R4_MAX) ? R4_MIN : cfg_q.ramp);
		wire  [31:0] dn_src = (TWO_CH_LIMITS && cfg_q.ctrl[CTRL_RDSEL]) ? cfg_q.ramp_dn
			: cfg_q.ramp;
		wire  [31:0] ramp_dn = TWO_CH_LIMITS ? ((dn_src < R2_MIN) ? R2_MIN : dn_src) :
			((dn_src < R4_MIN || dn_src > R4_MAX) ? R4_MIN : dn_src);
		wire  [31:0] ratio = (cfg_q.ratio < RATIO_MIN) ? RATIO_MIN :
			((cfg_q.ratio > RATIO_MAX) ? RATIO_MAX : cfg_q.ratio);
		wire  [63:0] cmd_prod = 64'(mag) * 64'(ratio);
		wire  [47:0] cmd_d    = 48'(cmd_prod) / RATIO_DEN;
		wire  [31:0] span     = tgt_f - start_f;
		wire  [31:0] up_div   = span / ramp_up;
		wire  [31:0] dn_div   = span / ramp_dn;
		// pulses left over a deceleration from the present frequency, trapezoid area
		wire  [63:0] dec_prod = 64'(freq_q + start_f) * 64'(ramp_dn);
		wire  [47:0] dec_pul  = 48'(dec_prod) / DEC_DIV;
		wire         running  = (st_q != PH_IDLE) && (st_q != PH_DONE);
		wire         start    = run & ~run_q & (st_q == PH_IDLE);
		wire         tick     = running & ~pause & (ms_cnt_q == MS_TICKS - 1);
		wire  [31:0] acc_sum  = acc_q + {freq_q[30:0], 1'b0};
		wire         wrap     = acc_sum >= CLK_HZ;
		wire         pstep    = running & ~pause & wrap & ~pulse_q;
		wire         mask_on  = ~cfg_q.mask[31] & (cfg_q.mask != 32'h0);
		wire         irq_ok   = ~mask_on | (out_cnt_q >= 48'(cfg_q.mask));
		wire         it_stop  = (stop_irq[i] & irq_ok) |
			((st_q == PH_DWELL) & (idle_cnt_q >= cfg_q.idle_lim));
		wire         fb_stop  = fb_cnt_q == mag;
		wire         stop_hit = running & (src_it ? it_stop : fb_stop);
		wire         near_end = (out_cnt_q + dec_pul) >= cmd_q;
		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				cfg_q <= '{ctrl: 5'h00, tgt_cnt: 32'h0, tgt_freq: 32'h0, se_freq: SERST,
					ramp: RAMP_RST, ramp_dn: RAMP_RST, ratio: RATIO_RST,
					idle_lim: IDLE_RST, mask: MASK_RST};
			end else if (wr_me) begin
				unique case (wr_ofs)
					OFS_CTRL:     if (w_strb_q[0]) cfg_q.ctrl <= w_data_q[4:0];
					OFS_TGT_CNT:  cfg_q.tgt_cnt <= wmerge(cfg_q.tgt_cnt, w_data_q, w_strb_q);
					OFS_TGT_FREQ: cfg_q.tgt_freq <= wmerge(cfg_q.tgt_freq, w_data_q, w_strb_q);
					OFS_SE_FREQ:  cfg_q.se_freq <= wmerge(cfg_q.se_freq, w_data_q, w_strb_q);
					OFS_RAMP:     cfg_q.ramp <= wmerge(cfg_q.ramp, w_data_q, w_strb_q);
					OFS_RAMP_DN:  cfg_q.ramp_dn <= wmerge(cfg_q.ramp_dn, w_data_q, w_strb_q);
					OFS_RATIO:    cfg_q.ratio <= wmerge(cfg_q.ratio, w_data_q, w_strb_q);
					OFS_IDLE:     cfg_q.idle_lim <= wmerge(cfg_q.idle_lim, w_data_q, w_strb_q);
					OFS_MASK:     cfg_q.mask <= wmerge(cfg_q.mask, w_data_q, w_strb_q);
					default:      ;
				endcase
			end
		end
		// millisecond tick, the ramp clock; frozen while paused
		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				ms_cnt_q <= 32'h0;
			end else if (!running || tick) begin
				ms_cnt_q <= 32'h0;
			end else if (!pause) begin
				ms_cnt_q <= ms_cnt_q + 32'h1;
			end
		end
		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				acc_q   <= 32'h0;
				pulse_q <= 1'b0;
			end else if (start || !running || stop_hit || pause) begin
				acc_q   <= 32'h0;
				pulse_q <= 1'b0;
			end else begin
				acc_q <= wrap ? (acc_sum - CLK_HZ) : acc_sum;
				if (wrap) pulse_q <= ~pulse_q;
			end
		end
		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				pv_q       <= 32'h0;
				out_cnt_q  <= 48'h0;
				fb_cnt_q   <= 32'h0;
				idle_cnt_q <= 32'h0;
			end else if (start) begin
				out_cnt_q  <= 48'h0;
				fb_cnt_q   <= 32'h0;
				idle_cnt_q <= 32'h0;
			end else begin
				if (pstep) begin
					pv_q      <= neg ? (pv_q - 32'h1) : (pv_q + 32'h1);
					out_cnt_q <= out_cnt_q + 48'h1;
				end
				if (running && fb_pulse[i]) fb_cnt_q <= fb_cnt_q + 32'h1;
				if (pstep && st_q == PH_DWELL) idle_cnt_q <= idle_cnt_q + 32'h1;
			end
		end
		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				run_q <= 1'b0;
				dir_q <= 1'b0;
			end else begin
				run_q <= run;
				if (!run) dir_q <= 1'b0;
				else if (start) dir_q <= neg ^ (TWO_CH_LIMITS & cfg_q.ctrl[CTRL_REV]);
			end
		end
		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				st_q      <= PH_IDLE;
				done_q    <= 1'b0;
				freq_q    <= 32'h0;
				up_step_q <= 32'h0;
				dn_step_q <= 32'h0;
				cmd_q     <= 48'h0;
			end else if (!run) begin
				st_q <= PH_IDLE;
			end else if (start) begin
				st_q      <= PH_ACCEL;
				done_q    <= 1'b0;
				freq_q    <= start_f;
				up_step_q <= (up_div == 32'h0) ? 32'h1 : up_div;
				dn_step_q <= (dn_div == 32'h0) ? 32'h1 : dn_div;
				cmd_q     <= cmd_d;
			end else if (stop_hit) begin
				st_q   <= PH_DONE;
				done_q <= 1'b1;
			end else begin
				unique case (st_q)
					PH_ACCEL: begin
						if (near_end) st_q <= PH_DECEL;
						else if (tick && freq_q + up_step_q >= tgt_f) begin
							freq_q <= tgt_f;
							st_q   <= PH_CRUISE;
						end else if (tick) freq_q <= freq_q + up_step_q;
					end
					PH_CRUISE: if (near_end) st_q <= PH_DECEL;
					PH_DECEL: begin
						if (tick && freq_q <= start_f + dn_step_q) begin
							freq_q <= start_f;
							st_q   <= PH_DWELL;
						end else if (tick) freq_q <= freq_q - dn_step_q;
					end
					PH_DWELL, PH_IDLE, PH_DONE: ;
					default: st_q <= PH_IDLE;
				endcase
			end
		end

		always_comb begin
			unique case (araddr[5:0])
				OFS_CTRL:     ch_rd[i] = {27'h0, cfg_q.ctrl};
				OFS_TGT_CNT:  ch_rd[i] = cfg_q.tgt_cnt;
				OFS_TGT_FREQ: ch_rd[i] = cfg_q.tgt_freq;
				OFS_SE_FREQ:  ch_rd[i] = cfg_q.se_freq;
				OFS_RAMP:     ch_rd[i] = cfg_q.ramp;
				OFS_RAMP_DN:  ch_rd[i] = cfg_q.ramp_dn;
				OFS_RATIO:    ch_rd[i] = cfg_q.ratio;
				OFS_IDLE:     ch_rd[i] = cfg_q.idle_lim;
				OFS_PV_LO:    ch_rd[i] = {16'h0, pv_q[15:0]};
				OFS_PV_HI:    ch_rd[i] = {16'h0, pv_q[31:16]};
				OFS_STAT:     ch_rd[i] = {24'h0, st_q, mask_on, neg, pause & running,
					done_q, running};
				OFS_MASK:     ch_rd[i] = cfg_q.mask;
				default:      ch_rd[i] = 32'h0;
			endcase
		end

		assign pulse_out_pin[i] = pulse_q;
		assign dir_out_pin[i]   = dir_q;
	end
endmodule

// ### clpp_checker.sv
// Purpose: port checks of clpp_positioner
// Assumes: one mclk domain
// Notes:   pulse rate is watched on channel 0 only
`timescale 1ns/10ps
module clpp_checker #(
	parameter bit          TWO_CH_LIMITS = 1'b0,
	parameter int unsigned MS_TICKS      = 1
) (
	// clock and reset
	input wire logic                     mclk,
	input wire logic                     reset,
	// register bus
	input wire logic                     awvalid,
	input wire logic                     awready,
	input wire logic                     wvalid,
	input wire logic                     wready,
	input wire logic [1:0]               bresp,
	input wire logic                     bvalid,
	input wire logic                     bready,
	input wire logic                     arvalid,
	input wire logic                     arready,
	input wire logic [31:0]              rdata,
	input wire logic [1:0]               rresp,
	input wire logic                     rvalid,
	input wire logic                     rready,
	// motor drive
	input wire logic [clpp_pkg::NCH-1:0] pulse_out_pin,
	input wire logic [clpp_pkg::NCH-1:0] dir_out_pin
);
	import clpp_pkg::*;
	// half period at the top clamp, less a little accumulator jitter
	localparam logic [7:0] HALF_MIN = TWO_CH_LIMITS ? 8'h78 : 8'h3c;
	logic [7:0] gap_q;
	logic       prev_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			gap_q  <= 8'h00;
			prev_q <= 1'b0;
		end else begin
			prev_q <= pulse_out_pin[0];
			gap_q  <= (pulse_out_pin[0] != prev_q) ? 8'h00 : gap_q + {7'h00, gap_q != 8'hff};
		end
	end
	sequence s_wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_rd_taken;
		arvalid && arready;
	endsequence
	property p_aw_hold; awvalid && awready |=> !awready; endproperty
	property p_w_hold; wvalid && wready |=> !wready; endproperty
	property p_b_ans; s_wr_taken |-> ##[1:2] bvalid; endproperty
	property p_b_stand; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	property p_b_code; bvalid |-> bresp == 2'b00 || bresp == 2'b11; endproperty
	property p_ar_slot; s_rd_taken |=> !arready; endproperty
	property p_r_ans; s_rd_taken |=> rvalid; endproperty
	property p_r_stand; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
	property p_rate; $rose(pulse_out_pin[0]) |-> gap_q >= HALF_MIN; endproperty
	property p_dir_quiet; $changed(dir_out_pin[0]) |-> !pulse_out_pin[0]; endproperty
	a_aw_hold: assert property (p_aw_hold) else $error("address slot not held");
	a_w_hold: assert property (p_w_hold) else $error("data slot not held");
	a_b_ans: assert property (p_b_ans) else $error("write response late");
	a_b_stand: assert property (p_b_stand) else $error("write response dropped");
	a_b_code: assert property (p_b_code) else $error("bad write response code");
	a_ar_slot: assert property (p_ar_slot) else $error("read slot not held");
	a_r_ans: assert property (p_r_ans) else $error("read answer late");
	a_r_stand: assert property (p_r_stand) else $error("read answer dropped");
	a_rate: assert property (p_rate) else $error("pulse faster than clamp");
	a_dir_quiet: assert property (p_dir_quiet) else $error("direction moved under pulse");
endmodule

bind clpp_positioner clpp_checker #(.TWO_CH_LIMITS(TWO_CH_LIMITS), .MS_TICKS(MS_TICKS))
	clpp_checker_i (.mclk(mclk), .reset(reset), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
	.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
	.rready(rready), .pulse_out_pin(pulse_out_pin), .dir_out_pin(dir_out_pin));

// ### clpp_drive_model.sv
// Purpose: motor drive with encoder feedback, channel 0
// Assumes: one encoder strobe per drive step
// Notes:   stop strobe fires on a chosen step count, zero means never
`timescale 1ns/10ps
module clpp_drive_model (
	// clock and reset
	input wire logic        mclk,
	input wire logic        reset,
	// bench control
	input wire logic        clr,
	input wire logic [15:0] irq_at,
	// drive side
	input wire logic        step,
	// feedback side
	output logic            fb,
	output logic            stop,
	output logic [15:0]     steps_q
);
	logic      prev_q;
	wire logic edge_w = step & ~prev_q;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			prev_q  <= 1'b0;
			fb      <= 1'b0;
			stop    <= 1'b0;
			steps_q <= 16'h0000;
		end else begin
			prev_q  <= step;
			// stiff coupling: the encoder answers each step one mclk cycle after its rising edge
			fb      <= edge_w;
			stop    <= edge_w && (steps_q + 16'h0001 == irq_at);
			steps_q <= clr ? 16'h0000 : steps_q + {15'h0000, edge_w};
		end
	end
endmodule

// ### clpp_positioner_bench.sv
// Purpose: self-checking bench of clpp_positioner
// Assumes: MS_TICKS cut to 50 cycles, channel 0 exercised
// Notes:   register reads are checked by a monitor from a queue of notes
`timescale 1ns/10ps
module clpp_positioner_bench;
	import clpp_pkg::*;
	typedef struct packed {
		logic [1:0]  resp;
		logic [31:0] data;
		logic [31:0] mask;
	} clpp_exp_s;
	logic             mclk       = 1'b0;
	logic             reset      = 1'b0;
	logic [7:0]       awaddr     = 8'h00;
	logic             awvalid    = 1'b0;
	logic [31:0]      wdata      = 32'h0;
	logic [3:0]       wstrb      = 4'hf;
	logic             wvalid     = 1'b0;
	logic             bready     = 1'b0;
	logic [7:0]       araddr     = 8'h00;
	logic             arvalid    = 1'b0;
	logic             rready     = 1'b0;
	logic             clr        = 1'b0;
	logic [15:0]      irq_at     = 16'h0;
	logic             awready, wready, bvalid, arready, rvalid;
	logic [1:0]       bresp, rresp, pulse_out_pin, dir_out_pin;
	logic [31:0]      rdata, q;
	wire logic [1:0]  fb_pulse, stop_irq;
	logic [15:0]      pcnt;
	int               fails      = 0;
	int               n_compared = 0;
	int               seed       = 32'h08ddbf29;
	int               i;
	clpp_exp_s        exp_r[$];
	clpp_exp_s        e;
	logic [1:0]       exp_b[$];
	logic [31:0]      rst_val [12] = '{32'h0, 32'h0, 32'h0, SE_FREQ_RST2, RAMP_RST, RAMP_RST,
		RATIO_RST, IDLE_RST, 32'h0, 32'h0, 32'h0, MASK_RST};
	assign fb_pulse[1] = 1'b0;
	assign stop_irq[1] = 1'b0;
	always #20 mclk = ~mclk;
	clpp_positioner #(.TWO_CH_LIMITS(1'b1), .MS_TICKS(50)) clpp_positioner_i (.mclk(mclk),
		.reset(reset), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .fb_pulse(fb_pulse),
		.stop_irq(stop_irq), .pulse_out_pin(pulse_out_pin), .dir_out_pin(dir_out_pin));
	clpp_drive_model clpp_drive_model_i (.mclk(mclk), .reset(reset), .clr(clr),
		.irq_at(irq_at), .step(pulse_out_pin[0]), .fb(fb_pulse[0]), .stop(stop_irq[0]),
		.steps_q(pcnt));
	task automatic check(input logic [33:0] got, input logic [33:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("compared %0d mismatched %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	function automatic logic [7:0] ad(input logic [5:0] o);
		return {2'b00, o};
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_b.push_back(r);
		@(posedge mclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		// no answer time is assumed; only the watchdog ends a lost answer
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [1:0] r, output logic [31:0] v);
		exp_r.push_back('{r, d, m});
		@(posedge mclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge mclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		v = rdata;
		rready <= 1'b0;
	endtask
	task automatic wait_done();
		rd(ad(OFS_STAT), 32'h0, 32'h0, 2'b00, q);
		while (q[1] !== 1'b1) begin
			repeat (100) @(posedge mclk);
			rd(ad(OFS_STAT), 32'h0, 32'h0, 2'b00, q);
		end
	endtask
	task automatic dir_is(input logic v);
		@(posedge mclk);
		check({33'h0, dir_out_pin[0]}, {33'h0, v});
	endtask
	task automatic quiet(input int n);
		logic any;
		any = 1'b0;
		repeat (n) begin
			@(posedge mclk);
			any = any | pulse_out_pin[0];
		end
		check({33'h0, any}, 34'h0);
	endtask
	task automatic zero();
		clr <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
	endtask
	always @(posedge mclk) begin
		if (rvalid && rready) begin
			e = exp_r.pop_front();
			check({rresp, rdata & e.mask}, {e.resp, e.data & e.mask});
		end
		if (bvalid && bready) check({32'h0, bresp}, {32'h0, exp_b.pop_front()});
	end
	initial begin
		repeat (60000) @(posedge mclk);
		fails++;
		stop_test();
	end
	initial begin
		reset <= 1'b1;
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		for (i = 0; i < 12; i++) rd(8'(i * 4), rst_val[i], 32'hffffffff, 2'b00, q);
		$display("test reset values done");
		wr(8'h30, 32'h1, 2'b11);
		rd(8'h30, 32'h0, 32'hffffffff, 2'b11, q);
		wr(8'h82, 32'h1, 2'b11);
		wr(ad(OFS_PV_LO), 32'h1234, 2'b00);
		rd(ad(OFS_PV_LO), 32'h0, 32'hffffffff, 2'b00, q);
		// channel 1 window must not alias channel 0
		q = $random(seed);
		wr(8'h44, q, 2'b00);
		rd(8'h44, q, 32'hffffffff, 2'b00, q);
		rd(ad(OFS_TGT_CNT), 32'h0, 32'hffffffff, 2'b00, q);
		$display("test unmapped done");
		wr(ad(OFS_TGT_CNT), 32'd20, 2'b00);
		wr(ad(OFS_TGT_FREQ), 32'h000f4240, 2'b00);
		wr(ad(OFS_SE_FREQ), 32'h0000c350, 2'b00);
		wr(ad(OFS_RAMP), 32'h14, 2'b00);
		wr(ad(OFS_RAMP_DN), 32'h14, 2'b00);
		wr(ad(OFS_CTRL), 32'h5, 2'b00);
		wait_done();
		check({18'h0, pcnt}, 34'd20);
		rd(ad(OFS_PV_LO), 32'd20, 32'h0000ffff, 2'b00, q);
		rd(ad(OFS_STAT), 32'ha2, 32'he2, 2'b00, q);
		check({33'h0, dir_out_pin[0]}, 34'h0);
		quiet(300);
		wr(ad(OFS_CTRL), 32'h0, 2'b00);
		$display("test counter stop done");
		zero();
		irq_at <= 16'd24 + 16'($unsigned($random(seed)) % 8);
		wr(ad(OFS_TGT_CNT), 32'hfffffffb, 2'b00);
		wr(ad(OFS_CTRL), 32'h2, 2'b00);
		wr(ad(OFS_CTRL), 32'h3, 2'b00);
		dir_is(1'b1);
		rd(ad(OFS_STAT), 32'h8, 32'h8, 2'b00, q);
		wait_done();
		check({18'h0, pcnt}, {18'h0, irq_at});
		// present value carries the 20 forward steps of the first run
		rd(ad(OFS_PV_LO), {16'h0, 16'd20 - irq_at}, 32'h0000ffff, 2'b00, q);
		rd(ad(OFS_PV_HI), 32'h0000ffff, 32'h0000ffff, 2'b00, q);
		dir_is(1'b1);
		wr(ad(OFS_CTRL), 32'h0, 2'b00);
		dir_is(1'b0);
		$display("test interrupt stop done");
		zero();
		wr(ad(OFS_TGT_CNT), 32'h3, 2'b00);
		wr(ad(OFS_CTRL), 32'h19, 2'b00);
		dir_is(1'b1);
		rd(ad(OFS_STAT), 32'h4, 32'h4, 2'b00, q);
		quiet(400);
		wr(ad(OFS_CTRL), 32'h9, 2'b00);
		wait_done();
		check({18'h0, pcnt}, 34'd3);
		wr(ad(OFS_CTRL), 32'h0, 2'b00);
		$display("test pause and reverse done");
		zero();
		wr(ad(OFS_IDLE), 32'h3, 2'b00);
		wr(ad(OFS_TGT_CNT), 32'h2, 2'b00);
		irq_at <= 16'h0;
		wr(ad(OFS_CTRL), 32'h2, 2'b00);
		wr(ad(OFS_CTRL), 32'h3, 2'b00);
		wait_done();
		check({18'h0, pcnt}, 34'd3);
		check({32'h0, pulse_out_pin[1], dir_out_pin[1]}, 34'h0);
		wr(ad(OFS_CTRL), 32'h0, 2'b00);
		$display("test idle limit done");
		stop_test();
	end
endmodule
